// ### src/cmb_defines.svh
// Constants for the processor board system-bus interface.
`ifndef CMB_DEFINES_SVH
`define CMB_DEFINES_SVH

// ************************************************************
// Clocking
// ************************************************************
`define CMB_CLK_PERIOD_NS 50
`define CMB_PHASE_FREQ_KHZ 800
`define CMB_PHASE_PERIOD_NS (1000000 / `CMB_PHASE_FREQ_KHZ)
`define CMB_PHASE_DIV (`CMB_PHASE_PERIOD_NS / `CMB_CLK_PERIOD_NS)
`define CMB_PHASE_CNT_W 5
`define CMB_PHI2_AT 5'hC
`define CMB_CYCLE_TIME_NS 12500
`define CMB_CYCLE_PHASES (`CMB_CYCLE_TIME_NS / `CMB_PHASE_PERIOD_NS)

// ************************************************************
// Bus layout
// ************************************************************
`define CMB_ADDR_W 14
`define CMB_DATA_W 8
`define CMB_PORT_W 5
`define CMB_PORT_LSB 9
`define CMB_IN_PORT_MAX 5'h07
`define CMB_STACK_DEPTH 7
`define CMB_SP_W 3
`define CMB_SP_FULL 3'h7
`define CMB_PC_RESET 14'h0000

`endif

// ### src/cmb_pkg.sv
// Types shared by the processor board system-bus interface.
package cmb_pkg;

	typedef enum logic [2:0] {
		CMB_MEM_RD = 3'b000,
		CMB_MEM_WR = 3'b001,
		CMB_IO_IN = 3'b010,
		CMB_IO_OUT = 3'b011,
		CMB_INT_FETCH = 3'b100
	} cmb_kind_e;

	typedef enum logic [1:0] {
		CMB_ST_IDLE = 2'b00,
		CMB_ST_XFER = 2'b01,
		CMB_ST_HOLD = 2'b10
	} cmb_state_e;

endpackage

// ### src/cmb_phase_gen.sv
// Two-phase timing generator: 800 kHz phases derived from the core clock.
`include "cmb_defines.svh"

module cmb_phase_gen (
	input wire logic core_clk_i,
	input wire logic resetn_i,
	output logic phi1_o,
	output logic phi2_o,
	output logic phi2_tick_o
);

	logic [`CMB_PHASE_CNT_W-1:0] cnt_reg;
	logic [`CMB_PHASE_CNT_W-1:0] cnt_next;
	wire cnt_last = (cnt_reg == `CMB_PHASE_CNT_W'(`CMB_PHASE_DIV - 1));
	wire phi2_start = (cnt_next == `CMB_PHI2_AT);

	assign cnt_next = cnt_last ? '0 : cnt_reg + `CMB_PHASE_CNT_W'(1);

	// Phase one covers the first part of each period, phase two the rest; they never overlap.
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cnt_reg <= '0;
			phi1_o <= 1'b0;
			phi2_o <= 1'b0;
			phi2_tick_o <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			phi1_o <= (cnt_next < `CMB_PHI2_AT);
			phi2_o <= (cnt_next >= `CMB_PHI2_AT);
			phi2_tick_o <= phi2_start;
		end
	end

endmodule

// ### src/cmb_bus_if.sv
// System-bus interface of the 8-bit processor board: splits core traffic onto board buses.
//
// Notes on behaviour
// - Drive 14-bit address, separate 8-bit data out/in.
// - Flat 16 KB memory, no paging logic.
// - Wait request stalls the cycle until released.
// - Port cycles place 5-bit port number upstairs.
// - Ports 0-7 input, 8-31 output only.
// - Port cycle qualifier plus read/write direction signal.
// - Port data uses separate out and in buses.
// - Interrupt fetches instruction byte from dedicated port.
// - After interrupt, program resumes where it stopped.
// - Execution data with flags latched on own bus.
// - Timing from two-phase 800 kHz clock.
// - Seven nested return levels kept internally.
// - Port number occupies address bits 9 to 13.
// - Restart clears only the program counter.
// - Alternate master may take bus; then resume.
`include "cmb_defines.svh"

module cmb_bus_if (
	input wire logic core_clk_i,
	input wire logic resetn_i,
	// Core side.
	input wire logic req_i,
	input wire cmb_pkg::cmb_kind_e req_kind_i,
	input wire logic [`CMB_ADDR_W-1:0] req_addr_i,
	input wire logic [`CMB_PORT_W-1:0] req_port_i,
	input wire logic [`CMB_DATA_W-1:0] req_wdata_i,
	input wire logic pc_inc_i,
	input wire logic jump_i,
	input wire logic call_i,
	input wire logic ret_i,
	input wire logic [`CMB_ADDR_W-1:0] target_i,
	input wire logic restart_i,
	input wire logic exec_strobe_i,
	input wire logic [`CMB_DATA_W-1:0] exec_data_i,
	output logic done_o,
	output logic refused_o,
	output logic [`CMB_DATA_W-1:0] rdata_o,
	output logic [`CMB_ADDR_W-1:0] pc_o,
	// Board bus side.
	output logic [`CMB_ADDR_W-1:0] mem_addr_o,
	output logic [`CMB_DATA_W-1:0] data_out_o,
	input wire logic [`CMB_DATA_W-1:0] mem_din_i,
	input wire logic [`CMB_DATA_W-1:0] io_din_i,
	output logic mem_rd_o,
	output logic mem_wr_o,
	input wire logic mem_wait_i,
	output logic io_cycle_o,
	output logic io_in_o,
	output logic io_out_o,
	input wire logic [`CMB_DATA_W-1:0] int_instr_i,
	output logic int_ack_o,
	output logic [`CMB_DATA_W-1:0] exec_data_o,
	input wire logic hold_req_i,
	output logic hold_ack_o,
	output logic phi1_o,
	output logic phi2_o
);

	// ************************************************************
	// Phase timing
	// ************************************************************
	logic phi2_tick;

	cmb_phase_gen u_phase (
		.core_clk_i(core_clk_i),
		.resetn_i(resetn_i),
		.phi1_o(phi1_o),
		.phi2_o(phi2_o),
		.phi2_tick_o(phi2_tick)
	);

	// ************************************************************
	// Request decode
	// ************************************************************
	cmb_pkg::cmb_state_e state_reg;
	cmb_pkg::cmb_state_e state_next;
	cmb_pkg::cmb_kind_e kind_reg;

	wire idle = (state_reg == cmb_pkg::CMB_ST_IDLE);
	wire xfer = (state_reg == cmb_pkg::CMB_ST_XFER);
	wire port_is_in = (req_port_i <= `CMB_IN_PORT_MAX);
	wire kind_io_in = (req_kind_i == cmb_pkg::CMB_IO_IN);
	wire kind_io_out = (req_kind_i == cmb_pkg::CMB_IO_OUT);
	wire kind_io = kind_io_in || kind_io_out;
	wire req_ok = kind_io_in ? port_is_in : kind_io_out ? !port_is_in : 1'b1;
	wire start_hold = idle && hold_req_i;
	wire take = idle && !hold_req_i && req_i && req_ok;
	wire refuse = idle && !hold_req_i && req_i && !req_ok;
	// A slow device stretches the cycle by holding wait; completion is only on a phase-two tick.
	wire finish = xfer && phi2_tick && !mem_wait_i;
	wire [`CMB_ADDR_W-1:0] port_addr = {req_port_i, {`CMB_PORT_LSB{1'b0}}};
	wire [`CMB_ADDR_W-1:0] addr_sel = kind_io ? port_addr : req_addr_i;
	wire [`CMB_DATA_W-1:0] rdata_sel =
		(kind_reg == cmb_pkg::CMB_IO_IN) ? io_din_i :
		(kind_reg == cmb_pkg::CMB_INT_FETCH) ? int_instr_i : mem_din_i;

	always_comb begin
		case (state_reg)
			cmb_pkg::CMB_ST_IDLE: state_next = start_hold ? cmb_pkg::CMB_ST_HOLD :
				take ? cmb_pkg::CMB_ST_XFER : cmb_pkg::CMB_ST_IDLE;
			cmb_pkg::CMB_ST_XFER: state_next = finish ? cmb_pkg::CMB_ST_IDLE : cmb_pkg::CMB_ST_XFER;
			cmb_pkg::CMB_ST_HOLD: state_next = hold_req_i ? cmb_pkg::CMB_ST_HOLD :
				cmb_pkg::CMB_ST_IDLE;
			default: state_next = cmb_pkg::CMB_ST_IDLE;
		endcase
	end

	// ************************************************************
	// Transfer sequencer
	// ************************************************************
	// Only one of mem_rd_o, mem_wr_o, io_cycle_o and int_ack_o is loaded per request, so the transfer types cannot overlap.
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_reg <= cmb_pkg::CMB_ST_IDLE;
			kind_reg <= cmb_pkg::CMB_MEM_RD;
			mem_addr_o <= '0;
			data_out_o <= '0;
			mem_rd_o <= 1'b0;
			mem_wr_o <= 1'b0;
			io_cycle_o <= 1'b0;
			io_in_o <= 1'b0;
			io_out_o <= 1'b0;
			int_ack_o <= 1'b0;
			hold_ack_o <= 1'b0;
			done_o <= 1'b0;
			refused_o <= 1'b0;
			rdata_o <= '0;
		end else begin
			state_reg <= state_next;
			done_o <= finish;
			refused_o <= refuse;
			hold_ack_o <= (state_next == cmb_pkg::CMB_ST_HOLD);
			if (take) begin
				kind_reg <= req_kind_i;
				mem_addr_o <= (req_kind_i == cmb_pkg::CMB_INT_FETCH) ? pc_o : addr_sel;
				data_out_o <= req_wdata_i;
				mem_rd_o <= (req_kind_i == cmb_pkg::CMB_MEM_RD);
				mem_wr_o <= (req_kind_i == cmb_pkg::CMB_MEM_WR);
				io_cycle_o <= kind_io;
				io_in_o <= kind_io_in;
				io_out_o <= kind_io_out;
				int_ack_o <= (req_kind_i == cmb_pkg::CMB_INT_FETCH);
			end else if (finish) begin
				rdata_o <= rdata_sel;
				mem_rd_o <= 1'b0;
				mem_wr_o <= 1'b0;
				io_cycle_o <= 1'b0;
				io_in_o <= 1'b0;
				io_out_o <= 1'b0;
				int_ack_o <= 1'b0;
			end
		end
	end

	// ************************************************************
	// Execution data latch
	// ************************************************************
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			exec_data_o <= '0;
		end else if (exec_strobe_i) begin
			exec_data_o <= exec_data_i;
		end
	end

	// ************************************************************
	// Program counter and return stack
	// ************************************************************
	// The stack is plain data with no reset, so a restart keeps the saved return addresses.
	logic [`CMB_ADDR_W-1:0] stack_mem [`CMB_STACK_DEPTH];
	logic [`CMB_SP_W-1:0] sp_reg;

	wire int_busy = xfer && (kind_reg == cmb_pkg::CMB_INT_FETCH);
	wire pc_frozen = int_busy || (state_reg == cmb_pkg::CMB_ST_HOLD);
	wire sp_full = (sp_reg == `CMB_SP_FULL);
	wire sp_empty = (sp_reg == '0);
	wire do_call = call_i && !pc_frozen && !restart_i;
	wire do_ret = ret_i && !call_i && !pc_frozen && !restart_i;
	wire [`CMB_SP_W-1:0] sp_top = sp_empty ? '0 : sp_reg - `CMB_SP_W'(1);
	wire [`CMB_SP_W-1:0] sp_push_idx = sp_full ? sp_top : sp_reg;
	wire [`CMB_ADDR_W-1:0] ret_addr = stack_mem[sp_top];

	always_ff @(posedge core_clk_i) begin
		if (do_call) begin
			stack_mem[sp_push_idx] <= pc_o;
		end
	end

	// A full stack overwrites its newest entry rather than spilling to memory.
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sp_reg <= '0;
			pc_o <= `CMB_PC_RESET;
		end else begin
			if (do_call && !sp_full) begin
				sp_reg <= sp_reg + `CMB_SP_W'(1);
			end else if (do_ret && !sp_empty) begin
				sp_reg <= sp_top;
			end
			if (restart_i) begin
				pc_o <= `CMB_PC_RESET;
			end else if (!pc_frozen) begin
				// A return outranks a jump, so a popped level is never lost to a jump target.
				if (do_call) begin
					pc_o <= target_i;
				end else if (do_ret) begin
					pc_o <= ret_addr;
				end else if (jump_i) begin
					pc_o <= target_i;
				end else if (pc_inc_i) begin
					pc_o <= pc_o + `CMB_ADDR_W'(1);
				end
			end
		end
	end

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!resetn_i);

	a_strobes_exclusive: assert property (
		$onehot0({mem_rd_o, mem_wr_o, io_cycle_o, int_ack_o}))
		else $error("More than one transfer type active.");
	a_wait_stall: assert property (
		(xfer && mem_wait_i) |=> (mem_rd_o || mem_wr_o || io_cycle_o || int_ack_o) && !done_o)
		else $error("Cycle ended while wait was asserted.");
	a_port_addr: assert property (
		(take && kind_io) |=> (mem_addr_o[13:9] == $past(req_port_i)) && (mem_addr_o[8:0] == '0))
		else $error("Port number not on address bits 9 to 13.");
	a_port_range: assert property (
		(io_in_o |-> mem_addr_o[13:9] <= `CMB_IN_PORT_MAX) and
		(io_out_o |-> mem_addr_o[13:9] > `CMB_IN_PORT_MAX))
		else $error("Port direction outside its range.");
	a_port_qualify: assert property (
		io_cycle_o |-> (io_in_o ^ io_out_o))
		else $error("Port cycle without exactly one direction.");
	a_int_resume: assert property (
		(int_busy && !restart_i) |=> pc_o == $past(pc_o))
		else $error("Program counter moved during interrupt fetch.");
	a_int_data: assert property (
		(finish && kind_reg == cmb_pkg::CMB_INT_FETCH) |=> done_o && rdata_o == $past(int_instr_i))
		else $error("Interrupt byte not returned.");
	a_exec_latch: assert property (
		exec_strobe_i |=> exec_data_o == $past(exec_data_i))
		else $error("Execution data not latched.");
	a_exec_hold: assert property (
		!exec_strobe_i |=> $stable(exec_data_o))
		else $error("Execution data changed without a strobe.");
	a_restart_zero: assert property (
		restart_i |=> pc_o == `CMB_PC_RESET && $stable(sp_reg))
		else $error("Restart did not clear only the program counter.");
	a_hold_quiet: assert property (
		hold_ack_o |-> !(mem_rd_o || mem_wr_o || io_cycle_o || int_ack_o))
		else $error("Strobe active while bus is granted away.");
	a_call_return: assert property (
		(do_call && !sp_full) ##1 (do_ret && !call_i) |=> pc_o == $past(pc_o, 2))
		else $error("Return did not restore the call address.");

endmodule

// ### verification/cmb_far_model.sv
// Far-side model: memory modules and port boards on the system bus.
module cmb_far_model (
	input wire logic clk_i,
	input wire logic [13:0] addr_i,
	input wire logic [7:0] dout_i,
	input wire logic rd_i,
	input wire logic wr_i,
	input wire logic in_i,
	input wire logic out_i,
	input wire logic [7:0] wait_len_i,
	output logic [7:0] mem_din_o,
	output logic [7:0] io_din_o,
	output logic wait_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] mem [2**14];
	logic [7:0] out_latch [2**5];
	logic [7:0] cnt = 8'h00;
	logic [7:0] junk = 8'h00;
	logic busy;
	logic [4:0] port;
	assign busy = rd_i | wr_i | in_i | out_i;
	assign port = addr_i[13:9];
	// A slow board stalls each cycle for its own count; zero answers at once.
	assign wait_o = busy && (cnt < wait_len_i);
	// Released lines carry a moving pattern, so a stale byte cannot pass.
	assign mem_din_o = rd_i ? mem[addr_i] : junk;
	assign io_din_o = (in_i && port < 5'h08) ? {3'h6, port} : junk;
	always @(posedge clk_i) begin
		cnt <= busy ? cnt + 8'h01 : 8'h00;
		junk <= junk + 8'h3B;
		if (wr_i)
			mem[addr_i] <= dout_i;
		if (out_i && port > 5'h07)
			out_latch[port] <= dout_i;
	end
endmodule

// ### verification/tb_top.sv
// Self-checking bench for the processor board system-bus interface.
`define CHK(a, b, m) begin num_checks++; if ((a) !== (b)) begin errors++; \
	$display("wrong value at %0t: %s", $time, m); end end
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk_i, resetn_i, req_i, pc_inc_i, jump_i, call_i, ret_i, restart_i, ov;
	logic exec_strobe_i, mem_wait_i, hold_req_i, done_o, refused_o, mem_rd_o, mem_wr_o;
	logic io_cycle_o, io_in_o, io_out_o, int_ack_o, hold_ack_o, phi1_o, phi2_o;
	cmb_pkg::cmb_kind_e req_kind_i;
	logic [13:0] req_addr_i, target_i, pc_o, mem_addr_o;
	logic [13:0] tg [8];
	logic [7:0] req_wdata_i, exec_data_i, rdata_o, data_out_o, mem_din_i, io_din_i;
	logic [7:0] int_instr_i, exec_data_o, wait_len, w;
	logic [4:0] req_port_i;
	logic [8:0] exp_q[$];
	logic [8:0] ev;
	int errors, num_checks, cycles, cyc, i, h;
	cmb_bus_if u_cmb_bus_if (.core_clk_i, .resetn_i, .req_i, .req_kind_i, .req_addr_i,
		.req_port_i, .req_wdata_i, .pc_inc_i, .jump_i, .call_i, .ret_i, .target_i, .restart_i,
		.exec_strobe_i, .exec_data_i, .done_o, .refused_o, .rdata_o, .pc_o, .mem_addr_o,
		.data_out_o, .mem_din_i, .io_din_i, .mem_rd_o, .mem_wr_o, .mem_wait_i, .io_cycle_o,
		.io_in_o, .io_out_o, .int_instr_i, .int_ack_o, .exec_data_o, .hold_req_i, .hold_ack_o,
		.phi1_o, .phi2_o);
	cmb_far_model u_cmb_far_model (.clk_i(core_clk_i), .addr_i(mem_addr_o),
		.dout_i(data_out_o), .rd_i(mem_rd_o), .wr_i(mem_wr_o), .in_i(io_in_o), .out_i(io_out_o),
		.wait_len_i(wait_len), .mem_din_o(mem_din_i), .io_din_o(io_din_i), .wait_o(mem_wait_i));
	initial begin
		core_clk_i = 1'b0;
		forever #25 core_clk_i = ~core_clk_i;
	end
	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// The watcher takes the oldest note whenever a transfer completes.
	always @(posedge core_clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			close_out();
		end
		#2;
		if (done_o === 1'b1) begin
			`CHK(exp_q.size() > 0, 1'b1, "completion without request")
			ev = exp_q.pop_front();
			if (ev[8])
				`CHK(rdata_o, ev[7:0], "read data")
		end
	end
	task automatic step();
		@(posedge core_clk_i);
		#5;
	endtask
	// Strobe set s is {rd, wr, io cycle, io in, io out, int ack}; zero means refused.
	task automatic xfer(input cmb_pkg::cmb_kind_e k, input logic [13:0] a,
		input logic [8:0] e, input logic [5:0] s);
		logic [5:0] seen;
		seen = 6'h00;
		step();
		cyc = 0;
		req_kind_i = k;
		req_addr_i = a;
		req_port_i = a[13:9];
		req_wdata_i = w;
		req_i = 1'b1;
		if (s != 6'h00)
			exp_q.push_back(e);
		do begin
			step();
			cyc++;
			seen |= {mem_rd_o, mem_wr_o, io_cycle_o, io_in_o, io_out_o, int_ack_o};
		end while (cyc < 400 && done_o !== 1'b1 && refused_o !== 1'b1);
		req_i = 1'b0;
		`CHK(refused_o, s == 6'h00, "refusal")
		`CHK(seen, s, "strobes")
		if (s != 6'h00)
			`CHK(mem_addr_o, a, "address bus")
	endtask
	task automatic pc_op(input logic [4:0] ops, input logic [13:0] t, input logic [13:0] e);
		{restart_i, call_i, ret_i, jump_i, pc_inc_i} = ops;
		target_i = t;
		step();
		`CHK(pc_o, e, "program counter")
	endtask
	initial begin
		{resetn_i, req_i, pc_inc_i, jump_i, call_i, ret_i, restart_i} = 7'h00;
		{exec_strobe_i, hold_req_i, req_port_i, wait_len, w} = 23'h000000;
		{req_addr_i, target_i, req_wdata_i, exec_data_i, int_instr_i} = 52'h0;
		req_kind_i = cmb_pkg::CMB_MEM_RD;
		void'($urandom(65260));
		repeat (16) @(posedge core_clk_i);
		#5;
		resetn_i = 1'b1;
		tg[0] = 14'h0000;
		tg[1] = 14'h3FFF;
		tg[2] = 14'($urandom);
		for (i = 0; i < 4; i++) begin
			wait_len = (i == 3) ? 8'h28 : 8'h00;
			w = 8'($urandom);
			xfer(cmb_pkg::CMB_MEM_WR, tg[i % 3], 9'h000, 6'h10);
			xfer(cmb_pkg::CMB_MEM_RD, tg[i % 3], {1'b1, w}, 6'h20);
		end
		`CHK(cyc > 40, 1'b1, "stall length")
		wait_len = 8'h00;
		$display("test memory done");
		for (i = 0; i < 32; i++) begin
			w = 8'($urandom);
			xfer(cmb_pkg::CMB_IO_IN, {5'(i), 9'h000}, {4'hE, 5'(i)}, i < 8 ? 6'h0C : 6'h00);
			xfer(cmb_pkg::CMB_IO_OUT, {5'(i), 9'h000}, 9'h000, i > 7 ? 6'h0A : 6'h00);
			if (i > 7)
				`CHK(u_cmb_far_model.out_latch[i], w, "port out data")
		end
		$display("test ports done");
		for (i = 0; i < 8; i++)
			tg[i] = 14'($urandom);
		pc_op(5'h02, tg[0], tg[0]);
		for (i = 1; i < 8; i++)
			pc_op(5'h08, tg[i], tg[i]);
		for (i = 6; i >= 0; i--)
			pc_op(5'h04, 14'h0000, tg[i]);
		pc_op(5'h00, 14'h0000, tg[0]);
		int_instr_i = 8'($urandom);
		xfer(cmb_pkg::CMB_INT_FETCH, pc_o, {1'b1, int_instr_i}, 6'h01);
		`CHK(pc_o, tg[0], "resume point")
		pc_op(5'h01, 14'h0000, tg[0] + 14'h0001);
		pc_op(5'h00, 14'h0000, tg[0] + 14'h0001);
		exec_data_i = 8'($urandom);
		w = exec_data_i;
		exec_strobe_i = 1'b1;
		step();
		exec_strobe_i = 1'b0;
		exec_data_i = ~w;
		step();
		`CHK(exec_data_o, w, "execution data")
		pc_op(5'h10, tg[3], 14'h0000);
		pc_op(5'h00, 14'h0000, 14'h0000);
		`CHK(exec_data_o, w, "kept on restart")
		$display("test program counter done");
		hold_req_i = 1'b1;
		req_kind_i = cmb_pkg::CMB_IO_IN;
		req_i = 1'b1;
		repeat (4) step();
		`CHK({hold_ack_o, io_cycle_o}, 2'b10, "hold grant")
		hold_req_i = 1'b0;
		xfer(cmb_pkg::CMB_IO_IN, {5'h03, 9'h000}, {4'hE, 5'h03}, 6'h0C);
		`CHK(hold_ack_o, 1'b0, "hold release")
		$display("test hold done");
		do step(); while (phi1_o !== 1'b0);
		do step(); while (phi1_o !== 1'b1);
		h = 0;
		ov = 1'b0;
		repeat (25) begin
			step();
			h += int'(phi1_o);
			ov |= ~(phi1_o ^ phi2_o);
		end
		`CHK({phi1_o, ov, 8'(h)}, {2'b10, 8'h0C}, "phase timing")
		$display("test phases done");
		close_out();
	end
endmodule
